// *** hw/jtp_pkg.sv ***
// package: tap states, instruction codes, chain lengths and timing for the test port
package jtp_pkg;
   localparam int IR_LEN = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_RESET_VAL = 4'hF;
   localparam int IDCODE_LEN = 32;
   // arbitrary identification value, not any real part's
   localparam logic [31:0] IDCODE_VAL = 32'h1234_5679;
   localparam int BSCAN_LEN = 8;
   localparam int PROG_LEN = 16;
   localparam int DBG_LEN = 16;
   localparam logic [3:0] INS_EXTEST = 4'h0;
   localparam logic [3:0] INS_IDCODE = 4'h1;
   localparam logic [3:0] INS_SAMPLE = 4'h2;
   localparam logic [3:0] INS_PROG = 4'h4;
   localparam logic [3:0] INS_DBG0 = 4'h8;
   localparam logic [3:0] INS_DBG1 = 4'h9;
   localparam logic [3:0] INS_BYPASS = 4'hF;
   localparam int RESET_TMS_HIGH = 5;
   localparam int SHIFT_W = 32;
   localparam int TCK_DIV = 4;
   typedef enum logic [3:0] {
      JTP_TLR = 4'h0, JTP_RTI = 4'h1, JTP_SEL_DR = 4'h3, JTP_CAP_DR = 4'h2,
      JTP_SH_DR = 4'h6, JTP_EX1_DR = 4'h7, JTP_PA_DR = 4'h5, JTP_EX2_DR = 4'h4,
      JTP_UPD_DR = 4'hC, JTP_SEL_IR = 4'hD, JTP_CAP_IR = 4'hF, JTP_SH_IR = 4'hE,
      JTP_EX1_IR = 4'hA, JTP_PA_IR = 4'hB, JTP_EX2_IR = 4'h9, JTP_UPD_IR = 4'h8
   } jtp_state_e;
endpackage

// *** hw/jtp_if.sv ***
// interface: the four test pins plus the open-collector system reset line
`timescale 1ns/1ps
interface jtp_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   logic sys_reset_n_in;
   logic sys_reset_pull;
   modport device (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport host (output tck, output tms, output tdi, input tdo, input tdo_oe,
      input sys_reset_n_in, output sys_reset_pull);
endinterface

// *** hw/jtp_fsm.sv ***
// tap state machine shared by both ends
`timescale 1ns/1ps
module jtp_fsm (
   input wire logic clk,
   input wire logic rst,
   input wire logic step,
   input wire logic tms,
   output jtp_pkg::jtp_state_e state
);
   import jtp_pkg::*;
   typedef struct packed {
      jtp_state_e st;
   } jtp_fsm_s;
   jtp_fsm_s q_r, q_nxt;
   always_comb begin
      q_nxt = q_r;
      if (step) begin
         case (q_r.st)
            JTP_TLR: q_nxt.st = tms ? JTP_TLR : JTP_RTI;
            JTP_RTI: q_nxt.st = tms ? JTP_SEL_DR : JTP_RTI;
            JTP_SEL_DR: q_nxt.st = tms ? JTP_SEL_IR : JTP_CAP_DR;
            JTP_CAP_DR: q_nxt.st = tms ? JTP_EX1_DR : JTP_SH_DR;
            JTP_SH_DR: q_nxt.st = tms ? JTP_EX1_DR : JTP_SH_DR;
            JTP_EX1_DR: q_nxt.st = tms ? JTP_UPD_DR : JTP_PA_DR;
            JTP_PA_DR: q_nxt.st = tms ? JTP_EX2_DR : JTP_PA_DR;
            JTP_EX2_DR: q_nxt.st = tms ? JTP_UPD_DR : JTP_SH_DR;
            JTP_UPD_DR: q_nxt.st = tms ? JTP_SEL_DR : JTP_RTI;
            JTP_SEL_IR: q_nxt.st = tms ? JTP_TLR : JTP_CAP_IR;
            JTP_CAP_IR: q_nxt.st = tms ? JTP_EX1_IR : JTP_SH_IR;
            JTP_SH_IR: q_nxt.st = tms ? JTP_EX1_IR : JTP_SH_IR;
            JTP_EX1_IR: q_nxt.st = tms ? JTP_UPD_IR : JTP_PA_IR;
            JTP_PA_IR: q_nxt.st = tms ? JTP_EX2_IR : JTP_PA_IR;
            JTP_EX2_IR: q_nxt.st = tms ? JTP_UPD_IR : JTP_SH_IR;
            JTP_UPD_IR: q_nxt.st = tms ? JTP_SEL_DR : JTP_RTI;
            default: q_nxt.st = JTP_TLR;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '{st: JTP_TLR};
      end else begin
         q_r <= q_nxt;
      end
   end
   assign state = q_r.st;
endmodule

// *** hw/jtp_device.sv ***
// device end: tap controller, instruction register and data chains on the test clock
`timescale 1ns/1ps
// Contract
// - sixteen-state controller stepped by tms on tck
// - power-on reset starts in test-logic-reset
// - all shift paths move lsb first
// - host enters shift-ir with tms 1,1,0,0
// - four-bit ir, msb in on exit
// - shift-ir outputs captured value 0001
// - tms 1,1,0 returns; update-ir loads instruction
// - tms 1,0,0 enters shift-dr; lsb first
// - shift-dr outputs values captured in capture-dr
// - latched outputs change only in update-dr
// - exit and pause states do nothing
// - five tms-high clocks reach test-logic-reset
// - unprogrammed fuse holds controller in reset
// - no dedicated test reset input
// - instruction picks ir or one data register
// - id, bypass, boundary, programming, debug chains
// - all test logic runs on tck
// - debugger watches and may pull system reset
// - data access without passing run-test/idle
// - enabled only when fuse set, disable clear
module jtp_device (
   input wire logic clk,
   input wire logic rst,
   jtp_if.device tap,
   input wire logic test_port_enable_fuse,
   input wire logic test_port_disable_bit,
   input wire logic [jtp_pkg::BSCAN_LEN-1:0] pin_sample,
   input wire logic [jtp_pkg::PROG_LEN-1:0] prog_status,
   input wire logic [jtp_pkg::DBG_LEN-1:0] dbg_status,
   output logic [jtp_pkg::IR_LEN-1:0] instr,
   output logic [jtp_pkg::BSCAN_LEN-1:0] pin_drive,
   output logic [jtp_pkg::PROG_LEN-1:0] prog_word,
   output logic [jtp_pkg::DBG_LEN-1:0] dbg_word,
   output logic port_pins_normal,
   output logic run_idle
);
   import jtp_pkg::*;
   typedef struct packed {
      logic en_meta;
      logic en_sync;
      logic [IR_LEN-1:0] ir_sh;
      logic [IR_LEN-1:0] ir;
      logic [SHIFT_W-1:0] dr_sh;
      logic [BSCAN_LEN-1:0] bs_out;
      logic [PROG_LEN-1:0] prog_out;
      logic [DBG_LEN-1:0] dbg_out;
   } jtp_dev_s;
   typedef struct packed {
      logic tdo;
      logic oe;
   } jtp_neg_s;
   jtp_dev_s q_r, q_nxt;
   jtp_neg_s n_r, n_nxt;
   jtp_state_e st;
   logic tap_rst;
   logic en_raw;
   // the enable bits live in the core clock domain; two flops bring them over
   assign en_raw = test_port_enable_fuse & ~test_port_disable_bit;
   // no trst pin: the only resets are power-on (rst), the enable and tms-high
   assign tap_rst = rst | ~q_r.en_sync;
   jtp_fsm u_fsm (
      .clk(tap.tck),
      .rst(tap_rst),
      .step(1'b1),
      .tms(tap.tms),
      .state(st)
   );
   always_comb begin
      q_nxt = q_r;
      q_nxt.en_meta = en_raw;
      q_nxt.en_sync = q_r.en_meta;
      case (st)
         JTP_TLR: q_nxt.ir = INS_IDCODE;
         JTP_CAP_IR: q_nxt.ir_sh = IR_CAPTURE;
         JTP_SH_IR: q_nxt.ir_sh = {tap.tdi, q_r.ir_sh[IR_LEN-1:1]};
         JTP_UPD_IR: q_nxt.ir = q_r.ir_sh;
         JTP_CAP_DR: begin
            q_nxt.dr_sh = '0;
            case (q_r.ir)
               INS_IDCODE: q_nxt.dr_sh = IDCODE_VAL;
               INS_EXTEST, INS_SAMPLE: q_nxt.dr_sh[BSCAN_LEN-1:0] = pin_sample;
               INS_PROG: q_nxt.dr_sh[PROG_LEN-1:0] = prog_status;
               INS_DBG0, INS_DBG1: q_nxt.dr_sh[DBG_LEN-1:0] = dbg_status;
               default: q_nxt.dr_sh = '0;
            endcase
         end
         JTP_SH_DR: begin
            case (q_r.ir)
               INS_IDCODE: q_nxt.dr_sh = {tap.tdi, q_r.dr_sh[SHIFT_W-1:1]};
               INS_EXTEST, INS_SAMPLE:
                  q_nxt.dr_sh[BSCAN_LEN-1:0] = {tap.tdi, q_r.dr_sh[BSCAN_LEN-1:1]};
               INS_PROG: q_nxt.dr_sh[PROG_LEN-1:0] = {tap.tdi, q_r.dr_sh[PROG_LEN-1:1]};
               INS_DBG0, INS_DBG1:
                  q_nxt.dr_sh[DBG_LEN-1:0] = {tap.tdi, q_r.dr_sh[DBG_LEN-1:1]};
               default: q_nxt.dr_sh[0] = tap.tdi;
            endcase
         end
         JTP_UPD_DR: begin
            case (q_r.ir)
               INS_EXTEST: q_nxt.bs_out = q_r.dr_sh[BSCAN_LEN-1:0];
               INS_PROG: q_nxt.prog_out = q_r.dr_sh[PROG_LEN-1:0];
               INS_DBG0, INS_DBG1: q_nxt.dbg_out = q_r.dr_sh[DBG_LEN-1:0];
               default: q_nxt.ir = q_r.ir;
            endcase
         end
         // exit and pause states leave every register but the enable synchroniser alone
         default: q_nxt.ir = q_r.ir;
      endcase
   end
   always_ff @(posedge tap.tck) begin
      if (tap_rst) begin
         // the enable synchroniser keeps running while the port is held in reset,
         // otherwise a disabled port could never come back
         q_r <= '{en_meta: en_raw & ~rst, en_sync: q_r.en_meta & ~rst, ir_sh: '0,
            ir: INS_IDCODE, dr_sh: '0, bs_out: '0, prog_out: '0, dbg_out: '0};
      end else begin
         q_r <= q_nxt;
      end
   end
   // falling edge output so the host samples a settled bit on the rising edge
   always_comb begin
      n_nxt.oe = (st == JTP_SH_IR) || (st == JTP_SH_DR);
      n_nxt.tdo = (st == JTP_SH_IR) ? q_r.ir_sh[0] : q_r.dr_sh[0];
   end
   always_ff @(negedge tap.tck) begin
      if (rst) begin
         n_r <= '{tdo: 1'b0, oe: 1'b0};
      end else begin
         n_r <= n_nxt;
      end
   end
   assign tap.tdo = n_r.tdo;
   assign tap.tdo_oe = n_r.oe;
   assign instr = q_r.ir;
   assign pin_drive = q_r.bs_out;
   assign prog_word = q_r.prog_out;
   assign dbg_word = q_r.dbg_out;
   assign port_pins_normal = ~q_r.en_sync;
   assign run_idle = (st == JTP_RTI);
endmodule

// *** hw/jtp_host.sv ***
// host end: drives tck from clk, walks the tap and shifts ir then dr
`timescale 1ns/1ps
module jtp_host (
   input wire logic clk,
   input wire logic rst,
   jtp_if.host tap,
   input wire logic req,
   input wire logic [jtp_pkg::IR_LEN-1:0] req_ir,
   input wire logic [jtp_pkg::SHIFT_W-1:0] req_dr,
   input wire logic [5:0] req_len,
   input wire logic reset_target,
   output logic busy,
   output logic done,
   output logic [jtp_pkg::SHIFT_W-1:0] rsp_dr,
   output logic [jtp_pkg::IR_LEN-1:0] rsp_ir,
   output logic target_in_reset
);
   import jtp_pkg::*;
   typedef struct packed {
      logic [1:0] div;
      logic tck;
      logic tms;
      logic tdi;
      logic [4:0] seq;
      logic [5:0] cnt;
      logic act;
      logic done;
      logic [IR_LEN-1:0] ir;
      logic [SHIFT_W-1:0] dr;
      logic [IR_LEN-1:0] ir_in;
      logic [SHIFT_W-1:0] dr_in;
      logic [5:0] len;
      logic rs_meta;
      logic rs_sync;
      logic [2:0] rst_cnt;
   } jtp_host_s;
   jtp_host_s q_r, q_nxt;
   jtp_state_e st;
   logic rise;
   assign rise = (q_r.div == 2'(TCK_DIV / 2 - 1)) && !q_r.tck;
   // host tracks the device state with its own copy stepped on each tck rise
   jtp_fsm u_fsm (
      .clk(clk),
      .rst(rst),
      .step(rise),
      .tms(q_r.tms),
      .state(st)
   );
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      q_nxt.rs_meta = tap.sys_reset_n_in;
      q_nxt.rs_sync = q_r.rs_meta;
      q_nxt.div = (q_r.div == 2'(TCK_DIV / 2 - 1)) ? 2'h0 : q_r.div + 2'h1;
      if (q_r.div == 2'(TCK_DIV / 2 - 1)) begin
         q_nxt.tck = ~q_r.tck;
         if (q_r.tck) begin
            // change tms/tdi on falling tck; device samples on rising
            q_nxt.tdi = 1'b0;
            if (q_r.rst_cnt != 3'(RESET_TMS_HIGH)) begin
               q_nxt.tms = 1'b1;
            end else if (!q_r.act) begin
               q_nxt.tms = 1'b0;
            end else begin
               case (st)
                  JTP_RTI: q_nxt.tms = 1'b1;
                  JTP_SEL_DR: q_nxt.tms = (q_r.seq == 5'h0);
                  JTP_SEL_IR, JTP_CAP_IR, JTP_CAP_DR: q_nxt.tms = 1'b0;
                  JTP_SH_IR: begin
                     q_nxt.tdi = q_r.ir[q_r.cnt[1:0]];
                     q_nxt.tms = (q_r.cnt == 6'(IR_LEN - 1));
                  end
                  JTP_SH_DR: begin
                     q_nxt.tdi = q_r.dr[q_r.cnt[4:0]];
                     q_nxt.tms = (q_r.cnt == q_r.len - 6'h1);
                  end
                  JTP_EX1_IR, JTP_EX1_DR: q_nxt.tms = 1'b1;
                  // straight on to the data branch without passing idle
                  JTP_UPD_IR: q_nxt.tms = 1'b1;
                  default: q_nxt.tms = 1'b0;
               endcase
            end
         end else begin
            if (q_r.rst_cnt != 3'(RESET_TMS_HIGH)) begin
               q_nxt.rst_cnt = q_r.rst_cnt + 3'h1;
            end
            if (st == JTP_SH_IR || st == JTP_SH_DR) begin
               q_nxt.cnt = q_r.cnt + 6'h1;
            end
            if (st == JTP_SH_IR) begin
               q_nxt.ir_in = {tap.tdo, q_r.ir_in[IR_LEN-1:1]};
            end
            if (st == JTP_SH_DR) begin
               q_nxt.dr_in = {tap.tdo, q_r.dr_in[SHIFT_W-1:1]};
            end
            if (st == JTP_UPD_IR) begin
               q_nxt.seq = 5'h1;
               q_nxt.cnt = '0;
            end
            if (st == JTP_UPD_DR) begin
               q_nxt.act = 1'b0;
               q_nxt.done = 1'b1;
            end
         end
      end
      if (req && !q_r.act && q_r.rst_cnt == 3'(RESET_TMS_HIGH) && st == JTP_RTI) begin
         q_nxt.act = 1'b1;
         q_nxt.seq = 5'h0;
         q_nxt.cnt = '0;
         q_nxt.ir = req_ir;
         q_nxt.dr = req_dr;
         q_nxt.len = (req_len == 6'h0) ? 6'h1 : req_len;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '{div: 2'h0, tck: 1'b0, tms: 1'b1, tdi: 1'b0, seq: '0, cnt: '0, act: 1'b0,
            done: 1'b0, ir: '0, dr: '0, ir_in: '0, dr_in: '0, len: '0, rs_meta: 1'b1,
            rs_sync: 1'b1, rst_cnt: '0};
      end else begin
         q_r <= q_nxt;
      end
   end
   assign tap.tck = q_r.tck;
   assign tap.tms = q_r.tms;
   assign tap.tdi = q_r.tdi;
   assign tap.sys_reset_pull = reset_target;
   // a request is only taken in idle, so report busy until the walk has reached it
   assign busy = q_r.act | (q_r.rst_cnt != 3'(RESET_TMS_HIGH)) | (st != JTP_RTI);
   assign done = q_r.done;
   assign rsp_dr = q_r.dr_in;
   assign rsp_ir = q_r.ir_in;
   assign target_in_reset = ~q_r.rs_sync;
endmodule

// *** verification/jtp_props.sv ***
// checker: tap walk, captured instruction and pin timing on the test port
`timescale 1ns/1ps
module jtp_props
   import jtp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic test_port_enable_fuse,
   input wire logic test_port_disable_bit
);
   typedef struct packed {
      jtp_state_e st;
      logic [2:0] cnt;
      logic tck_d;
   } jtp_chk_s;
   jtp_chk_s m_r;
   jtp_chk_s m_nxt;
   // the device follows enable changes two tck rises late, so watch nothing while off
   wire logic off = rst || test_port_disable_bit || !test_port_enable_fuse;
   function automatic jtp_state_e step(jtp_state_e s, logic t);
      case (s)
         JTP_TLR: return t ? JTP_TLR : JTP_RTI;
         JTP_RTI: return t ? JTP_SEL_DR : JTP_RTI;
         JTP_SEL_DR: return t ? JTP_SEL_IR : JTP_CAP_DR;
         JTP_CAP_DR, JTP_SH_DR: return t ? JTP_EX1_DR : JTP_SH_DR;
         JTP_EX1_DR: return t ? JTP_UPD_DR : JTP_PA_DR;
         JTP_PA_DR: return t ? JTP_EX2_DR : JTP_PA_DR;
         JTP_EX2_DR: return t ? JTP_UPD_DR : JTP_SH_DR;
         JTP_SEL_IR: return t ? JTP_TLR : JTP_CAP_IR;
         JTP_CAP_IR, JTP_SH_IR: return t ? JTP_EX1_IR : JTP_SH_IR;
         JTP_EX1_IR: return t ? JTP_UPD_IR : JTP_PA_IR;
         JTP_PA_IR: return t ? JTP_EX2_IR : JTP_PA_IR;
         JTP_EX2_IR: return t ? JTP_UPD_IR : JTP_SH_IR;
         default: return t ? JTP_SEL_DR : JTP_RTI;
      endcase
   endfunction
   // the model runs on clk and steps one clk after each tck rise, because tck
   // stands still during reset and a tck-clocked model would keep a stale state
   always_comb begin
      m_nxt = m_r;
      m_nxt.tck_d = tck;
      if (off) begin
         m_nxt.st = JTP_TLR;
         m_nxt.cnt = 3'h0;
      end else if (tck && !m_r.tck_d) begin
         m_nxt.st = step(m_r.st, tms);
         m_nxt.cnt = (m_r.st == JTP_SH_IR) ? m_r.cnt + 3'h1 : 3'h0;
      end
   end
   always_ff @(posedge clk) begin
      m_r <= m_nxt;
   end
   sequence ir_walk_s;
      tms ##1 !tms ##1 !tms;
   endsequence
   sequence ir_bits_s;
      !tms [*4] ##1 tms;
   endsequence
   a_oe_shift_only: assert property (@(posedge tck) disable iff (off)
      tdo_oe == (m_r.st == JTP_SH_IR || m_r.st == JTP_SH_DR)) else $error("oe outside shift");
   a_ir_capture_out: assert property (@(posedge tck) disable iff (off)
      m_r.st == JTP_SH_IR |-> tdo == IR_CAPTURE[m_r.cnt[1:0]]) else $error("bad ir capture bit");
   a_ir_entry_walk: assert property (@(posedge tck) disable iff (off)
      m_r.st == JTP_RTI && tms |=> ir_walk_s) else $error("bad walk to shift-ir");
   a_ir_four_bits: assert property (@(posedge tck) disable iff (off)
      m_r.st == JTP_CAP_IR |-> ir_bits_s) else $error("ir not four bits");
   a_ir_to_dr: assert property (@(posedge tck) disable iff (off)
      m_r.st == JTP_EX1_IR |-> tms ##1 tms ##1 !tms) else $error("bad walk ir to dr");
   a_dr_return_idle: assert property (@(posedge tck) disable iff (off)
      m_r.st == JTP_EX1_DR |-> tms ##1 !tms) else $error("bad walk dr to idle");
   a_tdo_fall_only: assert property (@(posedge clk) disable iff (off)
      tck && $past(tck) |-> $stable(tdo)) else $error("tdo moved while tck high");
   a_host_fall_only: assert property (@(posedge clk) disable iff (off)
      tck && $past(tck) |-> $stable(tms) && $stable(tdi)) else $error("tms or tdi moved");
endmodule

// *** verification/jtag_tap_controller_test.sv ***
// testbench: host and device ends joined, transfers per instruction and enable controls
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
   $display("CHECK FAILED %0t: got %h exp %h", $time, (got), (exp)); end end
module jtag_tap_controller_test;
   import jtp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic test_port_enable_fuse = 1'b1;
   logic test_port_disable_bit = 1'b0;
   logic ext_rst_n = 1'b1;
   logic req = 1'b0;
   logic [3:0] req_ir = 4'h0;
   logic [31:0] req_dr = 32'h0;
   logic [5:0] req_len = 6'h1;
   logic reset_target = 1'b0;
   logic [7:0] pin_sample = 8'hA5;
   logic [15:0] prog_status = 16'h3C5A;
   logic [15:0] dbg_status = 16'h9E17;
   logic busy, done, target_in_reset, port_pins_normal, run_idle;
   logic [31:0] rsp_dr;
   logic [3:0] rsp_ir, instr;
   logic [7:0] pin_drive;
   logic [15:0] prog_word, dbg_word;
   int n_fail = 0;
   int checked = 0;
   jtp_if bus ();
   // open-collector system reset line with a pull-up
   assign bus.sys_reset_n_in = ext_rst_n && !bus.sys_reset_pull;
   jtp_host i_jtp_host (.clk(clk), .rst(rst), .tap(bus.host), .req(req), .req_ir(req_ir),
      .req_dr(req_dr), .req_len(req_len), .reset_target(reset_target), .busy(busy),
      .done(done), .rsp_dr(rsp_dr), .rsp_ir(rsp_ir), .target_in_reset(target_in_reset));
   jtp_device i_jtp_device (.clk(clk), .rst(rst), .tap(bus.device),
      .test_port_enable_fuse(test_port_enable_fuse),
      .test_port_disable_bit(test_port_disable_bit), .pin_sample(pin_sample),
      .prog_status(prog_status), .dbg_status(dbg_status), .instr(instr),
      .pin_drive(pin_drive), .prog_word(prog_word), .dbg_word(dbg_word),
      .port_pins_normal(port_pins_normal), .run_idle(run_idle));
   jtp_props i_jtp_props (.clk(clk), .rst(rst), .tck(bus.tck), .tms(bus.tms), .tdi(bus.tdi),
      .tdo(bus.tdo), .tdo_oe(bus.tdo_oe), .test_port_enable_fuse(test_port_enable_fuse),
      .test_port_disable_bit(test_port_disable_bit));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic stop_test();
      if (n_fail == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_sig(input bit for_done);
      int n;
      n = 0;
      while (for_done ? done !== 1'b1 : busy !== 1'b0) begin
         tick(1);
         n++;
         if (n > 400) begin
            n_fail++;
            stop_test();
         end
      end
   endtask
   task automatic xfer(input logic [3:0] ir, input int len, input logic [31:0] d);
      wait_sig(1'b0);
      req_ir = ir;
      req_dr = d;
      req_len = 6'(len);
      req = 1'b1;
      tick(1);
      req = 1'b0;
      wait_sig(1'b1);
   endtask
   // the host shifts each tdo bit in at the top, so shift down to right-align
   task automatic run(input logic [3:0] ir, input int len, input logic [31:0] d,
         input logic [31:0] exp);
      xfer(ir, len, d);
      `CHK(rsp_dr >> (32 - len), exp)
      `CHK(rsp_ir, IR_CAPTURE)
      wait_sig(1'b0);
      `CHK(instr, ir)
      `CHK(run_idle, 1'b1)
   endtask
   initial begin
      tick(3);
      rst = 1'b0;
      wait_sig(1'b0);
      `CHK(instr, INS_IDCODE)
      `CHK(port_pins_normal, 1'b0)
      run(INS_IDCODE, 32, 32'h0, IDCODE_VAL);
      run(INS_BYPASS, 8, 32'hC3, 32'h86);
      run(4'h5, 8, 32'h5A, 32'hB4);
      run(INS_BYPASS, 1, 32'h1, 32'h0);
      run(INS_SAMPLE, 8, 32'h0F, 32'hA5);
      run(INS_EXTEST, 8, 32'h96, 32'hA5);
      `CHK(pin_drive, 8'h96)
      run(INS_IDCODE, 32, 32'h0, IDCODE_VAL);
      `CHK(pin_drive, 8'h96)
      run(INS_PROG, 16, 32'hBEEF, 32'h3C5A);
      `CHK(prog_word, 16'hBEEF)
      run(INS_DBG0, 16, 32'h1357, 32'h9E17);
      `CHK(dbg_word, 16'h1357)
      run(INS_DBG1, 16, 32'h2468, 32'h9E17);
      `CHK(dbg_word, 16'h2468)
      test_port_disable_bit = 1'b1;
      xfer(INS_BYPASS, 8, 32'h0);
      `CHK(port_pins_normal, 1'b1)
      `CHK(instr, INS_IDCODE)
      test_port_disable_bit = 1'b0;
      test_port_enable_fuse = 1'b0;
      xfer(INS_BYPASS, 8, 32'h0);
      `CHK(port_pins_normal, 1'b1)
      test_port_enable_fuse = 1'b1;
      rst = 1'b1;
      tick(3 * TCK_DIV);
      rst = 1'b0;
      run(INS_BYPASS, 8, 32'hC3, 32'h86);
      `CHK(port_pins_normal, 1'b0)
      reset_target = 1'b1;
      tick(6);
      `CHK(bus.sys_reset_pull, 1'b1)
      `CHK(target_in_reset, 1'b1)
      reset_target = 1'b0;
      ext_rst_n = 1'b0;
      tick(6);
      `CHK(bus.sys_reset_pull, 1'b0)
      `CHK(target_in_reset, 1'b1)
      ext_rst_n = 1'b1;
      tick(6);
      `CHK(target_in_reset, 1'b0)
      stop_test();
   end
   initial begin
      #200000;
      n_fail++;
      stop_test();
   end
endmodule
